// file: core/cmdsel_pkg.sv
package cmdsel_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_FUNC   = 8'h04;
  localparam logic [7:0] ADDR_DECEL  = 8'h08;
  localparam logic [7:0] ADDR_FREQ   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQST  = 8'h14;
  localparam logic [7:0] ADDR_IRQMSK = 8'h18;
  localparam logic [7:0] ADDR_CTRL   = 8'h1c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LINK_MODE_LSB = 0;
  localparam int FB_MODE_LSB   = 8;
  localparam int LINK_FUNC_LSB = 0;
  localparam int STOP_FUNC_LSB = 8;
  localparam logic [3:0]  LINK_MODE_MAX   = 4'h8;
  localparam logic [1:0]  FB_MODE_MAX     = 2'h3;
  localparam logic [7:0]  FUNC_STOP_CODE  = 8'h1e;  // Forced-stop function code 30
  localparam logic [7:0]  FUNC_LINK_CODE  = 8'h18;
  localparam logic [7:0]  FUNC_RST        = 8'h00;
  localparam logic [15:0] DECEL_RST       = 16'h0064;
  localparam logic [15:0] FREQ_RST        = 16'h0000;

  // Interrupt bits
  localparam int IRQ_SRC_CHG = 0;
  localparam int IRQ_ALARM   = 1;
  localparam int IRQ_W       = 2;

  // ---------------------------------------------------------------
  // Timing: one ramp tick every STEP_US microseconds
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 25000000;
  localparam int STEP_US      = 10;
  localparam int STEP_CYCLES  = (CLK_HZ / 1000000) * STEP_US;

  // Command source codes
  typedef enum logic [1:0] {
    CMDSEL_SRC_INT  = 2'b00,
    CMDSEL_SRC_STD  = 2'b01,
    CMDSEL_SRC_OPT  = 2'b10,
    CMDSEL_SRC_FBUS = 2'b11
  } cmdsel_src_t;

  // Forced-stop states
  typedef enum logic [1:0] {
    CMDSEL_ST_RUN   = 2'b00,
    CMDSEL_ST_DECEL = 2'b01,
    CMDSEL_ST_ALARM = 2'b10
  } cmdsel_state_t;

  // One command source bundle
  typedef struct packed {
    logic [15:0] freq;
    logic        run;
  } cmdsel_cmd_t;

endpackage

// file: core/cmdsel_route.sv
`timescale 1ns/10ps
// Maps link and field bus mode settings onto the two command sources
module cmdsel_route (
  input  wire logic [3:0]           link_mode_select,
  input  wire logic [1:0]           fieldbus_mode_select,
  input  wire logic                 link_enable_input,
  output cmdsel_pkg::cmdsel_src_t   freq_src,
  output cmdsel_pkg::cmdsel_src_t   run_src
);

  // ---------------------------------------------------------------
  // Source decode
  // ---------------------------------------------------------------
  // Bad settings fall back to internal; safer than a stale remote source
  always_comb begin
    freq_src = cmdsel_pkg::CMDSEL_SRC_INT;
    run_src  = cmdsel_pkg::CMDSEL_SRC_INT;
    if (link_enable_input && link_mode_select <= cmdsel_pkg::LINK_MODE_MAX) begin
      case (link_mode_select)
        4'h1, 4'h3, 4'h7: freq_src = cmdsel_pkg::CMDSEL_SRC_STD;
        4'h4, 4'h5, 4'h8: freq_src = cmdsel_pkg::CMDSEL_SRC_OPT;
        default:          freq_src = cmdsel_pkg::CMDSEL_SRC_INT;
      endcase
      case (link_mode_select)
        4'h2, 4'h3, 4'h5: run_src = cmdsel_pkg::CMDSEL_SRC_STD;
        4'h6, 4'h7, 4'h8: run_src = cmdsel_pkg::CMDSEL_SRC_OPT;
        default:          run_src = cmdsel_pkg::CMDSEL_SRC_INT;
      endcase
      // Field bus overrides; mode 0 leaves link choice
      if (fieldbus_mode_select[0]) begin
        freq_src = cmdsel_pkg::CMDSEL_SRC_FBUS;
      end
      if (fieldbus_mode_select[1]) begin
        run_src = cmdsel_pkg::CMDSEL_SRC_FBUS;
      end
    end
    // Otherwise internal only
  end

endmodule

// file: core/cmdsel_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Link modes 0,2,6 give internal frequency; 1,3,7 give standard serial frequency.
// - Link modes 0,1,4 give internal run; 2,3,5 give standard serial run.
// - Option-card link gives frequency for 4,5,8 and run for 6,7,8.
// - Field bus mode 0 leaves both sources to the link mode.
// - Field bus mode 1 takes frequency, mode 2 takes run, from field bus.
// - Field bus mode 3 takes both commands from field bus for link modes 0 to 8.
// - Assigned link-enable input on makes both mode selections effective.
// - Link-enable input off forces internal sources for both commands.
// - Forced-stop input (function 30) on ramps output down over deceleration time.
// - Output reaching zero after forced stop enters alarm stop with alarm flag.
// - Internal sources are frequency selections or multistep, and keypad or terminals.
module cmdsel_top (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Command sources, same clock domain
  input  wire cmdsel_pkg::cmdsel_cmd_t int_cmd,
  input  wire cmdsel_pkg::cmdsel_cmd_t std_cmd,
  input  wire cmdsel_pkg::cmdsel_cmd_t opt_cmd,
  input  wire cmdsel_pkg::cmdsel_cmd_t fbus_cmd,
  // Digital input terminals (pins)
  input  wire logic                    link_enable_pin,
  input  wire logic                    forced_stop_pin,
  // Outputs
  output logic      [15:0]             out_freq,
  output logic                         out_run,
  output logic                         alarm_stop,
  output logic                         irq
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0]                link_mode_select_q;
  logic [1:0]                fieldbus_mode_select_q;
  localparam int IRQ_W_L = cmdsel_pkg::IRQ_W;
  logic [7:0]                link_func_q;
  logic [7:0]                stop_func_q;
  logic [15:0]               forced_stop_decel_time_q;
  logic [IRQ_W_L-1:0]        irq_stat_q;
  logic [IRQ_W_L-1:0]        irq_mask_q;
  logic                      alarm_clr;

  // Pin synchronisers
  logic [1:0]                link_sync_q;
  logic [1:0]                stop_sync_q;
  logic                      link_enable_input;
  logic                      forced_stop_on;

  // Routing and ramp
  cmdsel_pkg::cmdsel_src_t   freq_src;
  cmdsel_pkg::cmdsel_src_t   run_src;
  cmdsel_pkg::cmdsel_src_t   freq_src_q;
  cmdsel_pkg::cmdsel_src_t   run_src_q;
  cmdsel_pkg::cmdsel_state_t state_q;
  logic [15:0]               sel_freq;
  logic                      sel_run;
  logic [15:0]               ramp_q;
  logic [15:0]               step_cnt_q;
  logic [15:0]               ms_cnt_q;
  logic                      tick;
  logic                      stop_done;
  logic                      src_chg;

  logic                      wr_en;
  logic                      rd_en;
  logic                      addr_ok;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  always_comb begin
    case (paddr)
      cmdsel_pkg::ADDR_MODE, cmdsel_pkg::ADDR_FUNC, cmdsel_pkg::ADDR_DECEL,
      cmdsel_pkg::ADDR_FREQ, cmdsel_pkg::ADDR_STATUS, cmdsel_pkg::ADDR_IRQST,
      cmdsel_pkg::ADDR_IRQMSK, cmdsel_pkg::ADDR_CTRL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  // Configuration writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_mode_select_q       <= 4'h0;
      fieldbus_mode_select_q   <= 2'h0;
      link_func_q              <= cmdsel_pkg::FUNC_RST;
      stop_func_q              <= cmdsel_pkg::FUNC_RST;
      forced_stop_decel_time_q <= cmdsel_pkg::DECEL_RST;
      irq_mask_q               <= '0;
    end else if (wr_en) begin
      case (paddr)
        cmdsel_pkg::ADDR_MODE: begin
          link_mode_select_q     <= pwdata[cmdsel_pkg::LINK_MODE_LSB +: 4];
          fieldbus_mode_select_q <= pwdata[cmdsel_pkg::FB_MODE_LSB +: 2];
        end
        cmdsel_pkg::ADDR_FUNC: begin
          link_func_q <= pwdata[cmdsel_pkg::LINK_FUNC_LSB +: 8];
          stop_func_q <= pwdata[cmdsel_pkg::STOP_FUNC_LSB +: 8];
        end
        cmdsel_pkg::ADDR_DECEL:  forced_stop_decel_time_q <= pwdata[15:0];
        cmdsel_pkg::ADDR_IRQMSK: irq_mask_q <= pwdata[IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  // Writing one to bit 0 of the control word releases the alarm stop while the forced-stop input is off
  assign alarm_clr = wr_en && (paddr == cmdsel_pkg::ADDR_CTRL) && pwdata[0];

  // Read mux; data registered from the bus inputs is already stable
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        cmdsel_pkg::ADDR_MODE:   prdata = {22'h0, fieldbus_mode_select_q, 4'h0,
                                           link_mode_select_q};
        cmdsel_pkg::ADDR_FUNC:   prdata = {16'h0, stop_func_q, link_func_q};
        cmdsel_pkg::ADDR_DECEL:  prdata = {16'h0, forced_stop_decel_time_q};
        cmdsel_pkg::ADDR_FREQ:   prdata = {16'h0, out_freq};
        cmdsel_pkg::ADDR_STATUS: prdata = {24'h0, state_q, run_src_q, freq_src_q,
                                           link_enable_input, out_run};
        cmdsel_pkg::ADDR_IRQST:  prdata = {30'h0, irq_stat_q};
        cmdsel_pkg::ADDR_IRQMSK: prdata = {30'h0, irq_mask_q};
        default:                 prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      link_sync_q <= 2'b00;
      stop_sync_q <= 2'b00;
    end else begin
      link_sync_q <= {link_sync_q[0], link_enable_pin};
      stop_sync_q <= {stop_sync_q[0], forced_stop_pin};
    end
  end

  // Each function works only while assigned to its terminal
  assign link_enable_input = (link_func_q == cmdsel_pkg::FUNC_LINK_CODE) &&
                             link_sync_q[1];
  assign forced_stop_on    = (stop_func_q == cmdsel_pkg::FUNC_STOP_CODE) &&
                             stop_sync_q[1];

  // ---------------------------------------------------------------
  // Source routing
  // ---------------------------------------------------------------
  cmdsel_route u_route (
    .link_mode_select     (link_mode_select_q),
    .fieldbus_mode_select (fieldbus_mode_select_q),
    .link_enable_input    (link_enable_input),
    .freq_src             (freq_src),
    .run_src              (run_src)
  );

  // Source multiplexers
  always_comb begin
    case (freq_src_q)
      cmdsel_pkg::CMDSEL_SRC_STD:  sel_freq = std_cmd.freq;
      cmdsel_pkg::CMDSEL_SRC_OPT:  sel_freq = opt_cmd.freq;
      cmdsel_pkg::CMDSEL_SRC_FBUS: sel_freq = fbus_cmd.freq;
      default:                     sel_freq = int_cmd.freq;
    endcase
    case (run_src_q)
      cmdsel_pkg::CMDSEL_SRC_STD:  sel_run = std_cmd.run;
      cmdsel_pkg::CMDSEL_SRC_OPT:  sel_run = opt_cmd.run;
      cmdsel_pkg::CMDSEL_SRC_FBUS: sel_run = fbus_cmd.run;
      default:                     sel_run = int_cmd.run;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_src_q <= cmdsel_pkg::CMDSEL_SRC_INT;
      run_src_q  <= cmdsel_pkg::CMDSEL_SRC_INT;
    end else begin
      freq_src_q <= freq_src;
      run_src_q  <= run_src;
    end
  end
  assign src_chg = (freq_src != freq_src_q) || (run_src != run_src_q);

  // ---------------------------------------------------------------
  // Forced stop ramp
  // ---------------------------------------------------------------
  // Ramp drops one unit every decel-time-plus-one ticks, so zero is fastest
  assign tick      = (ms_cnt_q == 16'(cmdsel_pkg::STEP_CYCLES - 1));
  assign stop_done = (state_q == cmdsel_pkg::CMDSEL_ST_DECEL) && (ramp_q == 16'h0000);

  always_ff @(posedge core_clk) begin
    if (rst || state_q != cmdsel_pkg::CMDSEL_ST_DECEL || tick) begin
      ms_cnt_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q    <= cmdsel_pkg::CMDSEL_ST_RUN;
      ramp_q     <= cmdsel_pkg::FREQ_RST;
      step_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        cmdsel_pkg::CMDSEL_ST_RUN: begin
          ramp_q     <= sel_run ? sel_freq : 16'h0000;
          step_cnt_q <= 16'h0000;
          if (forced_stop_on) begin
            state_q <= cmdsel_pkg::CMDSEL_ST_DECEL;
          end
        end
        cmdsel_pkg::CMDSEL_ST_DECEL: begin
          if (ramp_q == 16'h0000) begin
            state_q <= cmdsel_pkg::CMDSEL_ST_ALARM;
          end else if (tick) begin
            if (step_cnt_q >= forced_stop_decel_time_q) begin
              step_cnt_q <= 16'h0000;
              ramp_q     <= ramp_q - 16'h0001;
            end else begin
              step_cnt_q <= step_cnt_q + 16'h0001;
            end
          end
        end
        cmdsel_pkg::CMDSEL_ST_ALARM: begin
          ramp_q <= 16'h0000;
          if (alarm_clr && !forced_stop_on) begin
            state_q <= cmdsel_pkg::CMDSEL_ST_RUN;
          end
        end
        default: state_q <= cmdsel_pkg::CMDSEL_ST_RUN;
      endcase
    end
  end

  assign out_freq   = ramp_q;
  assign out_run    = (state_q == cmdsel_pkg::CMDSEL_ST_RUN) && sel_run;
  assign alarm_stop = (state_q == cmdsel_pkg::CMDSEL_ST_ALARM);

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q[cmdsel_pkg::IRQ_SRC_CHG] <= src_chg ||
        (irq_stat_q[cmdsel_pkg::IRQ_SRC_CHG] &&
         !(wr_en && paddr == cmdsel_pkg::ADDR_IRQST && pwdata[cmdsel_pkg::IRQ_SRC_CHG]));
      irq_stat_q[cmdsel_pkg::IRQ_ALARM] <= stop_done ||
        (irq_stat_q[cmdsel_pkg::IRQ_ALARM] &&
         !(wr_en && paddr == cmdsel_pkg::ADDR_IRQST && pwdata[cmdsel_pkg::IRQ_ALARM]));
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_LINK_OFF_INTERNAL: assert property (@(posedge core_clk) disable iff (rst)
    !link_enable_input |=> (freq_src_q == cmdsel_pkg::CMDSEL_SRC_INT &&
                            run_src_q == cmdsel_pkg::CMDSEL_SRC_INT))
    else $error("Sources not internal with link disabled");
  AST_BAD_MODE: assert property (@(posedge core_clk) disable iff (rst)
    (link_mode_select_q > cmdsel_pkg::LINK_MODE_MAX) |-> (freq_src == cmdsel_pkg::CMDSEL_SRC_INT))
    else $error("Out-of-range link mode not internal");
  AST_FB_BOTH: assert property (@(posedge core_clk) disable iff (rst)
    (link_enable_input && fieldbus_mode_select_q == cmdsel_pkg::FB_MODE_MAX &&
     link_mode_select_q <= cmdsel_pkg::LINK_MODE_MAX)
    |-> (freq_src == cmdsel_pkg::CMDSEL_SRC_FBUS && run_src == cmdsel_pkg::CMDSEL_SRC_FBUS))
    else $error("Field bus mode 3 not routing both");
  AST_STD_FREQ: assert property (@(posedge core_clk) disable iff (rst)
    (link_enable_input && fieldbus_mode_select_q == 2'h0 && link_mode_select_q == 4'h7)
    |-> (freq_src == cmdsel_pkg::CMDSEL_SRC_STD && run_src == cmdsel_pkg::CMDSEL_SRC_OPT))
    else $error("Link mode 7 routed wrongly");
  AST_STD_RUN: assert property (@(posedge core_clk) disable iff (rst)
    (link_enable_input && fieldbus_mode_select_q == 2'h1 && link_mode_select_q == 4'h5)
    |-> (freq_src == cmdsel_pkg::CMDSEL_SRC_FBUS && run_src == cmdsel_pkg::CMDSEL_SRC_STD))
    else $error("Mixed mode routed wrongly");
  AST_STOP_ENTER: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == cmdsel_pkg::CMDSEL_ST_RUN && forced_stop_on)
    |=> (state_q == cmdsel_pkg::CMDSEL_ST_DECEL && !out_run))
    else $error("Forced stop did not start deceleration");
  AST_RAMP_DOWN: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == cmdsel_pkg::CMDSEL_ST_DECEL && $past(state_q) == cmdsel_pkg::CMDSEL_ST_DECEL)
    |-> (ramp_q <= $past(ramp_q)))
    else $error("Frequency rose during forced stop");
  AST_ALARM_AFTER: assert property (@(posedge core_clk) disable iff (rst)
    stop_done |=> (alarm_stop && irq_stat_q[cmdsel_pkg::IRQ_ALARM]))
    else $error("No alarm after forced stop");
endmodule

// file: tb/cmdsel_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Remote command sources: standard port, option card, field bus
// ---------------------------------------------------------------
module cmdsel_host_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  output cmdsel_pkg::cmdsel_cmd_t std_cmd,
  output cmdsel_pkg::cmdsel_cmd_t opt_cmd,
  output cmdsel_pkg::cmdsel_cmd_t fbus_cmd
);
  // Distinct values per source so a wrong route cannot look right;
  // the option card holds its run off so the run route shows too
  always_ff @(posedge core_clk) begin
    if (rst) begin
      std_cmd  <= '0;
      opt_cmd  <= '0;
      fbus_cmd <= '0;
    end else begin
      std_cmd  <= '{freq: 16'h0111, run: 1'b1};
      opt_cmd  <= '{freq: 16'h0222, run: 1'b0};
      fbus_cmd <= '{freq: 16'h0333, run: 1'b1};
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic                    core_clk        = 1'b0;
  logic                    rst             = 1'b1;
  logic                    psel            = 1'b0;
  logic                    penable         = 1'b0;
  logic                    pwrite          = 1'b0;
  logic [7:0]              paddr           = 8'h00;
  logic [31:0]             pwdata          = 32'h0;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  cmdsel_pkg::cmdsel_cmd_t int_cmd         = '{freq: 16'h0044, run: 1'b1};
  cmdsel_pkg::cmdsel_cmd_t std_cmd;
  cmdsel_pkg::cmdsel_cmd_t opt_cmd;
  cmdsel_pkg::cmdsel_cmd_t fbus_cmd;
  logic                    link_enable_pin = 1'b0;
  logic                    forced_stop_pin = 1'b0;
  logic [15:0]             out_freq;
  logic                    out_run;
  logic                    alarm_stop;
  logic                    irq;
  logic [31:0]             rd;
  logic                    err;
  int                      n_mismatch      = 0;
  int                      n_compared      = 0;

  always #20 core_clk = ~core_clk;

  cmdsel_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .int_cmd(int_cmd), .std_cmd(std_cmd), .opt_cmd(opt_cmd),
    .fbus_cmd(fbus_cmd), .link_enable_pin(link_enable_pin),
    .forced_stop_pin(forced_stop_pin), .out_freq(out_freq), .out_run(out_run),
    .alarm_stop(alarm_stop), .irq(irq));
  cmdsel_host_model host (.core_clk(core_clk), .rst(rst), .std_cmd(std_cmd),
    .opt_cmd(opt_cmd), .fbus_cmd(fbus_cmd));

  // ---------------------------------------------------------------
  // APB master: entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for a pready that never comes
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Expected sources, worked out from the selection tables
  function automatic logic [1:0] exp_fsrc(input int lm, input int fb, input bit en);
    if (!en || lm > 8) return cmdsel_pkg::CMDSEL_SRC_INT;
    if (fb == 1 || fb == 3) return cmdsel_pkg::CMDSEL_SRC_FBUS;
    if (lm == 1 || lm == 3 || lm == 7) return cmdsel_pkg::CMDSEL_SRC_STD;
    if (lm == 4 || lm == 5 || lm == 8) return cmdsel_pkg::CMDSEL_SRC_OPT;
    return cmdsel_pkg::CMDSEL_SRC_INT;
  endfunction
  function automatic logic [1:0] exp_rsrc(input int lm, input int fb, input bit en);
    if (!en || lm > 8) return cmdsel_pkg::CMDSEL_SRC_INT;
    if (fb == 2 || fb == 3) return cmdsel_pkg::CMDSEL_SRC_FBUS;
    if (lm == 2 || lm == 3 || lm == 5) return cmdsel_pkg::CMDSEL_SRC_STD;
    if (lm == 6 || lm == 7 || lm == 8) return cmdsel_pkg::CMDSEL_SRC_OPT;
    return cmdsel_pkg::CMDSEL_SRC_INT;
  endfunction
  function automatic cmdsel_pkg::cmdsel_cmd_t pick(input logic [1:0] s);
    case (s)
      2'h1:    return '{freq: 16'h0111, run: 1'b1};
      2'h2:    return '{freq: 16'h0222, run: 1'b0};
      2'h3:    return '{freq: 16'h0333, run: 1'b1};
      default: return int_cmd;
    endcase
  endfunction

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    logic [1:0] fs;
    logic [1:0] rs;
    int         cnt;
    cmdsel_pkg::cmdsel_cmd_t ef;
    cmdsel_pkg::cmdsel_cmd_t er;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK({alarm_stop, irq, out_freq}, 18'h0)
    apb(1'b0, cmdsel_pkg::ADDR_DECEL, 32'h0);
    `CHK(rd, 32'h00000064)
    apb(1'b1, 8'h20, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("test registers done");
    // Every link mode and field bus mode, with link enable off and on
    apb(1'b1, cmdsel_pkg::ADDR_FUNC, 32'h00001e18);
    for (int pe = 0; pe < 2; pe++) begin
      link_enable_pin <= pe[0];
      for (int fb = 0; fb < 4; fb++) begin
        for (int lm = 0; lm < 16; lm++) begin
          apb(1'b1, cmdsel_pkg::ADDR_MODE, 32'(fb * 256 + lm));
          repeat (4) @(posedge core_clk);
          fs = exp_fsrc(lm, fb, pe[0]);
          rs = exp_rsrc(lm, fb, pe[0]);
          ef = pick(fs);
          er = pick(rs);
          apb(1'b0, cmdsel_pkg::ADDR_STATUS, 32'h0);
          `CHK(rd[3:2], fs)
          `CHK(rd[5:4], rs)
          `CHK(rd[1:0], {pe[0], er.run})
          `CHK({out_run, out_freq}, {er.run, er.run ? ef.freq : 16'h0})
        end
      end
    end
    // A route change raises the source-change flag
    apb(1'b1, cmdsel_pkg::ADDR_IRQST, 32'h3);
    apb(1'b1, cmdsel_pkg::ADDR_MODE, 32'h00000303);
    repeat (2) @(posedge core_clk);
    apb(1'b0, cmdsel_pkg::ADDR_IRQST, 32'h0);
    `CHK(rd[1:0], 2'h1)
    // Pin on but the terminal not assigned to link enable
    apb(1'b1, cmdsel_pkg::ADDR_FUNC, 32'h00001e00);
    apb(1'b1, cmdsel_pkg::ADDR_MODE, 32'h00000303);
    repeat (4) @(posedge core_clk);
    apb(1'b0, cmdsel_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[5:1], 5'h0)
    $display("test routing done");
    // Forced stop from frequency 3, one step per tick
    apb(1'b1, cmdsel_pkg::ADDR_MODE, 32'h0);
    apb(1'b1, cmdsel_pkg::ADDR_DECEL, 32'h0);
    apb(1'b1, cmdsel_pkg::ADDR_IRQMSK, 32'h0);
    int_cmd <= '{freq: 16'h0003, run: 1'b1};
    repeat (4) @(posedge core_clk);
    apb(1'b1, cmdsel_pkg::ADDR_IRQST, 32'h3);
    `CHK(out_freq, 16'h0003)
    apb(1'b0, cmdsel_pkg::ADDR_FREQ, 32'h0);
    `CHK(rd, 32'h00000003)
    forced_stop_pin <= 1'b1;
    cnt = 0;
    while (alarm_stop !== 1'b1 && cnt < 2000) begin
      @(posedge core_clk);
      cnt++;
    end
    // Three steps of 250 cycles, the first timed from entry into deceleration
    `CHK(cnt >= 500 && cnt <= 760, 1'b1)
    `CHK({alarm_stop, out_freq, irq}, {1'b1, 16'h0, 1'b0})
    @(posedge core_clk);
    apb(1'b0, cmdsel_pkg::ADDR_IRQST, 32'h0);
    `CHK(rd[1], 1'b1)
    apb(1'b1, cmdsel_pkg::ADDR_IRQMSK, 32'h2);
    `CHK(irq, 1'b1)
    apb(1'b1, cmdsel_pkg::ADDR_IRQST, 32'h2);
    `CHK(irq, 1'b0)
    apb(1'b0, cmdsel_pkg::ADDR_IRQST, 32'h0);
    `CHK(rd[1], 1'b0)
    forced_stop_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    apb(1'b1, cmdsel_pkg::ADDR_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    `CHK(alarm_stop, 1'b0)
    // Decel time 1 doubles each step: one unit from frequency 1 takes two ticks
    int_cmd <= '{freq: 16'h0001, run: 1'b1};
    apb(1'b1, cmdsel_pkg::ADDR_DECEL, 32'h1);
    repeat (2) @(posedge core_clk);
    forced_stop_pin <= 1'b1;
    cnt = 0;
    while (alarm_stop !== 1'b1 && cnt < 2000) begin
      @(posedge core_clk);
      cnt++;
    end
    `CHK(cnt >= 500 && cnt <= 510, 1'b1)
    apb(1'b0, cmdsel_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[7:6], 2'h2)
    $display("test forced stop done");
    conclude();
  end
endmodule
